//--- verilog/adcc_defines.svh
// Register indices, field positions, reset values and timing counts
// for the converter control block.
// Assumes a 32-bit AXI4-Lite bus, one register per aligned word.
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH

// Register indices; byte address is four times the index
`define ADCC_IDX_MODE      10'h0C4
`define ADCC_IDX_RESULT    10'h0C5
`define ADCC_IDX_START     10'h0C6
`define ADCC_IDX_IRQ_STAT  10'h0C7
`define ADCC_IDX_IRQ_MASK  10'h0C8

// Bus address width in bits
`define ADCC_AW            12

// Mode register fields
`define ADCC_MODE_CLKSEL_BIT 7
`define ADCC_MODE_TRGEN_BIT  6
`define ADCC_MODE_RSV      2'h3
`define ADCC_MODE_RST      8'h30

// Start/status register fields
`define ADCC_RUN_BIT       7
`define ADCC_START_RSV     7'h7F

// Interrupt status bits
`define ADCC_IRQ_DONE_BIT  0
`define ADCC_IRQ_TRIG_BIT  1
`define ADCC_IRQ_W         2

// Conversion period in system clock cycles
`define ADCC_PERIOD_SLOW   6'h3E
`define ADCC_PERIOD_FAST   6'h1F

// Bus responses
`define ADCC_RESP_OKAY     2'h0
`define ADCC_RESP_SLVERR   2'h2

`endif

//--- verilog/adcc_pkg.sv
// Types shared by the converter control block and its timer.
// Assumes adcc_defines.svh is on the include path.
`include "adcc_defines.svh"

package adcc_pkg;

   // Conversion timer states
   typedef enum logic [0:0] {
      ADCC_IDLE = 1'b0,
      ADCC_RUN  = 1'b1
   } adcc_tmr_state_t;

   // Whole state of the timer
   typedef struct packed {
      adcc_tmr_state_t state;
      logic [5:0]      cnt;
   } adcc_tmr_t;

   // Whole state of the control block
   typedef struct packed {
      logic                    aw_held;
      logic [`ADCC_AW-1:0]     awaddr;
      logic                    w_held;
      logic [31:0]             wdata;
      logic [3:0]              wstrb;
      logic                    bvalid;
      logic [1:0]              bresp;
      logic                    rvalid;
      logic [31:0]             rdata;
      logic [1:0]              rresp;
      logic [7:0]              mode;
      logic                    run;
      logic [7:0]              result;
      logic [`ADCC_IRQ_W-1:0]  irq_stat;
      logic [`ADCC_IRQ_W-1:0]  irq_mask;
      logic [2:0]              trg_sync;
      logic [7:0]              data_s1;
      logic [7:0]              data_s2;
   } adcc_state_t;

endpackage : adcc_pkg

//--- verilog/adcc_conv_if.sv
// Control/timing handshake between the register side and the timer.
// Assumes both ends run on the same aclk.
`timescale 1ns/1ps

interface adcc_conv_if;
   logic start;  // Pulse: (re)start a conversion
   logic stop;   // Pulse: abort the running conversion
   logic fast;   // Level: short conversion period selected
   logic done;   // Pulse: conversion period elapsed
   logic busy;   // Level: timer counting

   modport ctl (output start, output stop, output fast, input done, input busy);
   modport tmr (input start, input stop, input fast, output done, output busy);
endinterface : adcc_conv_if

//--- verilog/adcc_conv_timer.sv
// Conversion period timer for the converter control block.
// Assumes start/stop are one-cycle pulses on aclk.
`timescale 1ns/1ps

module adcc_conv_timer
   import adcc_pkg::*;
(
   input  wire logic  aclk,
   input  wire logic  aresetn,
   adcc_conv_if.tmr   cv
);

   adcc_tmr_t st_ff;       // Registered state
   adcc_tmr_t nxt_st;      // Next state
   logic      period_end;  // Last counted cycle, run not cut short

   // Next-state logic; a start always reloads, so start beats stop
   always_comb begin
      nxt_st   = st_ff;
      period_end = 1'b0;
      case (st_ff.state)
         ADCC_IDLE: begin
            if (cv.start) begin
               nxt_st.state = ADCC_RUN;
               nxt_st.cnt   = cv.fast ? `ADCC_PERIOD_FAST - 6'd1
                                      : `ADCC_PERIOD_SLOW - 6'd1;
            end
         end
         ADCC_RUN: begin
            if (cv.start) begin
               // Restart from full period
               nxt_st.cnt = cv.fast ? `ADCC_PERIOD_FAST - 6'd1
                                    : `ADCC_PERIOD_SLOW - 6'd1;
            end else if (cv.stop) begin
               nxt_st.state = ADCC_IDLE;
               nxt_st.cnt   = 6'h00;
            end else if (st_ff.cnt == 6'h00) begin
               nxt_st.state = ADCC_IDLE;
               period_end   = 1'b1;
            end else begin
               nxt_st.cnt = st_ff.cnt - 6'd1;
            end
         end
         default: begin
            nxt_st = '{state: ADCC_IDLE, cnt: 6'h00};
         end
      endcase
   end

   // State registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= '{state: ADCC_IDLE, cnt: 6'h00};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // End strobe straight from the count: the run flag then drops on
   // the 62nd or 31st edge after the start, not one edge late
   assign cv.done = period_end;
   assign cv.busy = (st_ff.state == ADCC_RUN);

endmodule : adcc_conv_timer

//--- verilog/adcc_ctrl.sv
// Converter control block: AXI4-Lite registers, trigger pin, result
// capture and interrupt.
// Operation
// - trigger disabled means pin edges ignored
// - trigger enabled starts conversion on either edge
// - 8-bit read-only result register at index C5
// - run flag bit 7: write starts/stops, reads progress
// Assumes trigger pin and converter data are asynchronous to aclk;
// the analog front end holds adc_data stable at the end of a period.
// Registers are at most 8 bits wide, in the low byte lane of each word.
// The channel field is stored and driven out, nothing more.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps

module adcc_ctrl
   import adcc_pkg::*;
(
   input  wire logic                aclk,
   input  wire logic                aresetn,
   // Write address channel
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [`ADCC_AW-1:0] s_axi_awaddr,
   // Write data channel
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   // Write response channel
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   output logic [1:0]               s_axi_bresp,
   // Read address channel
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   input  wire logic [`ADCC_AW-1:0] s_axi_araddr,
   // Read data channel
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   // Converter side
   input  wire logic                conv_trigger_pin,
   input  wire logic [7:0]          adc_data,
   output logic [3:0]               conv_channel,
   output logic                     conv_busy,
   output logic                     irq
);

   // Reset image of the whole state
   // Result starts at zero, though software must not rely on it
   localparam adcc_state_t RST = '{
      aw_held:  1'b0,
      awaddr:   '0,
      w_held:   1'b0,
      wdata:    32'h0000_0000,
      wstrb:    4'h0,
      bvalid:   1'b0,
      bresp:    `ADCC_RESP_OKAY,
      rvalid:   1'b0,
      rdata:    32'h0000_0000,
      rresp:    `ADCC_RESP_OKAY,
      mode:     `ADCC_MODE_RST,
      run:      1'b0,
      result:   8'h00,
      irq_stat: '0,
      irq_mask: '0,
      trg_sync: 3'h0,
      data_s1:  8'h00,
      data_s2:  8'h00
   };

   adcc_state_t st_ff;   // Registered state
   adcc_state_t nxt_st;  // Next state

   adcc_conv_if cv ();   // Link to the period timer

   // Decoded bus events
   // All of them are pure gates on flops and bus inputs
   logic        aw_take;     // Address handshake this cycle
   logic        w_take;      // Data handshake this cycle
   logic        wr_fire;     // Both halves held, do the write
   logic [9:0]  wr_idx;      // Word index of the write
   logic [9:0]  rd_idx;      // Word index of the read
   logic        ar_take;     // Read address handshake
   logic        wr_lane0;    // Low byte lane enabled

   // Converter events
   // One-cycle strobes, each valid only in its own cycle
   logic        trg_edge;    // Either edge seen on the trigger pin
   logic        trg_start;   // Edge accepted as a start
   logic        sw_start;    // Software wrote a one to the run flag
   logic        sw_stop;     // Software wrote a zero to the run flag
   logic        irq_rd_clr;  // Read of interrupt status
   logic [`ADCC_IRQ_W-1:0] irq_evt;  // Events this cycle

   // Period timer
   // Separate module so the count can be checked on its own
   adcc_conv_timer u_timer (
      .aclk    (aclk),
      .aresetn (aresetn),
      .cv      (cv.tmr)
   );

   // Handshake readies; one write and one read in flight at most
   // Each half is parked in its own holding flop, so address and
   // data may arrive in either order or on the same edge.
   // A pending response blocks both halves: no second write starts
   // before the master has taken the first answer.
   assign s_axi_awready = !st_ff.aw_held && !st_ff.bvalid;
   assign s_axi_wready  = !st_ff.w_held && !st_ff.bvalid;
   assign s_axi_arready = !st_ff.rvalid;

   // Transfers happen where valid meets ready
   assign aw_take  = s_axi_awvalid && s_axi_awready;
   assign w_take   = s_axi_wvalid && s_axi_wready;
   assign ar_take  = s_axi_arvalid && s_axi_arready;
   assign wr_fire  = st_ff.aw_held && st_ff.w_held;
   assign wr_idx   = st_ff.awaddr[11:2];
   assign rd_idx   = s_axi_araddr[11:2];
   assign wr_lane0 = st_ff.wstrb[0];

   // Edge of the synchronised pin; the first stage is not looked at.
   // Stages one and two tame metastability, stage three is history,
   // so a pin change reaches the timer three edges later.
   // Limitation: a level held for under one clock may be missed.
   // Either direction counts; the enable bit alone gates the start.
   assign trg_edge  = st_ff.trg_sync[1] ^ st_ff.trg_sync[2];
   assign trg_start = trg_edge && st_ff.mode[`ADCC_MODE_TRGEN_BIT];

   // Run flag writes need the low lane
   // Decoded from the held word, one edge after both halves landed
   assign sw_start = wr_fire && wr_lane0 && (wr_idx == `ADCC_IDX_START)
                     && st_ff.wdata[`ADCC_RUN_BIT];
   assign sw_stop  = wr_fire && wr_lane0 && (wr_idx == `ADCC_IDX_START)
                     && !st_ff.wdata[`ADCC_RUN_BIT];

   // Status read clears on the address handshake
   // The data word is built from the old status in the same cycle,
   // so the master still sees the bits that it is clearing.
   assign irq_rd_clr = ar_take && (rd_idx == `ADCC_IDX_IRQ_STAT);

   // Event vector for the sticky status
   // Bit 0 marks a finished period, bit 1 an accepted pin start
   always_comb begin
      // Unused positions stay zero
      irq_evt                     = '0;
      irq_evt[`ADCC_IRQ_DONE_BIT] = cv.done;
      irq_evt[`ADCC_IRQ_TRIG_BIT] = trg_start;
   end

   // Timer control; a start pulse always reloads the full period
   // The select bit is read live, so changing it mid-run alters
   // only the next load, never the count already under way.
   // Keeping the conversion time long enough is left to software.
   assign cv.start = sw_start || trg_start;
   assign cv.stop  = sw_stop;
   assign cv.fast  = st_ff.mode[`ADCC_MODE_CLKSEL_BIT];

   // Next-state logic for bus, registers, sync chains and interrupt
   always_comb begin
      // Default: every field holds its value
      nxt_st = st_ff;

      // Synchronisers: pin and converter data
      // The sample word crosses without a handshake; this is safe only
      // because the front end holds it steady through a whole period.
      nxt_st.trg_sync = {st_ff.trg_sync[1:0], conv_trigger_pin};
      nxt_st.data_s1  = adc_data;
      nxt_st.data_s2  = st_ff.data_s1;

      // Capture of the write address
      // Held until the write fires; awready stays low meanwhile
      if (aw_take) begin
         nxt_st.aw_held = 1'b1;
         nxt_st.awaddr  = s_axi_awaddr;
      end

      // Capture of the write data
      // Strobes kept so the decode can honour the low lane
      if (w_take) begin
         nxt_st.w_held = 1'b1;
         nxt_st.wdata  = s_axi_wdata;
         nxt_st.wstrb  = s_axi_wstrb;
      end

      // Register write once both halves are in
      // Costs one edge over a direct write but keeps the decode
      // off the bus inputs; the answer follows on the next edge.
      if (wr_fire) begin
         nxt_st.aw_held = 1'b0;
         nxt_st.w_held  = 1'b0;
         nxt_st.bvalid  = 1'b1;
         nxt_st.bresp   = `ADCC_RESP_OKAY;
         case (wr_idx)
            `ADCC_IDX_MODE: begin
               if (wr_lane0) begin
                  // Reserved bits are stored but read back as ones
                  nxt_st.mode = st_ff.wdata[7:0];
               end
            end
            `ADCC_IDX_START: begin
               // Run flag handled below with its set/clear priority
               // so that a start and a stop never fight here
            end
            `ADCC_IDX_IRQ_MASK: begin
               if (wr_lane0) begin
                  // Upper bits of the word are ignored
                  nxt_st.irq_mask = st_ff.wdata[`ADCC_IRQ_W-1:0];
               end
            end
            `ADCC_IDX_RESULT,
            `ADCC_IDX_IRQ_STAT: begin
               // Read-only words: write dropped, answer still OKAY
               // Software gets no error for a harmless write
            end
            default: begin
               // Unknown index: nothing stored
               nxt_st.bresp = `ADCC_RESP_SLVERR;
            end
         endcase
      end

      // Write response leaves on bready
      // Answer and response code stand until the master takes them
      if (st_ff.bvalid && s_axi_bready) begin
         nxt_st.bvalid = 1'b0;
      end

      // Read: data registered one cycle after the address
      // Reserved bits read as ones, unused upper bits as zeros;
      // an unknown index answers with an error and zero data.
      if (ar_take) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp  = `ADCC_RESP_OKAY;
         nxt_st.rdata  = 32'h0000_0000;
         case (rd_idx)
            `ADCC_IDX_MODE: begin
               nxt_st.rdata[7:0] = {st_ff.mode[7:6], `ADCC_MODE_RSV,
                                    st_ff.mode[3:0]};
            end
            `ADCC_IDX_RESULT: begin
               nxt_st.rdata[7:0] = st_ff.result;
            end
            `ADCC_IDX_START: begin
               nxt_st.rdata[7:0] = {st_ff.run, `ADCC_START_RSV};
            end
            `ADCC_IDX_IRQ_STAT: begin
               nxt_st.rdata[`ADCC_IRQ_W-1:0] = st_ff.irq_stat;
            end
            `ADCC_IDX_IRQ_MASK: begin
               nxt_st.rdata[`ADCC_IRQ_W-1:0] = st_ff.irq_mask;
            end
            default: begin
               // Unknown index: data stays zero
               nxt_st.rresp = `ADCC_RESP_SLVERR;
            end
         endcase
      end else if (st_ff.rvalid && s_axi_rready) begin
         // Read data leaves once the master takes it
         nxt_st.rvalid = 1'b0;
      end

      // Run flag: a start in the same cycle as a stop or end wins
      // A start during a run restarts the full period and keeps the
      // flag high; an idle timer also drops it, so the flag can
      // never outlive the count that it reports.
      if (sw_start || trg_start) begin
         nxt_st.run = 1'b1;
      end else if (sw_stop || cv.done || !cv.busy) begin
         nxt_st.run = 1'b0;
      end

      // Result only changes when a period completes normally
      // An aborted run leaves the previous result in place
      if (cv.done) begin
         nxt_st.result = st_ff.data_s2;
      end

      // Sticky status; an event in the clearing cycle survives
      // Set beats clear, so no event is lost to a read in flight
      nxt_st.irq_stat = (irq_rd_clr ? '0 : st_ff.irq_stat) | irq_evt;
   end

   // All state in one register
   // Synchronous reset; also flushes any half-taken bus transfer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Outputs, all from flip-flops
   // The interrupt is a gate on two registers, so it cannot glitch
   // on a bus input; it stays high until software reads the status or clears its mask bit.
   assign s_axi_bvalid = st_ff.bvalid;
   assign s_axi_bresp  = st_ff.bresp;
   assign s_axi_rvalid = st_ff.rvalid;
   assign s_axi_rdata  = st_ff.rdata;
   assign s_axi_rresp  = st_ff.rresp;
   assign conv_channel = st_ff.mode[3:0];
   assign conv_busy    = st_ff.run;
   assign irq          = |(st_ff.irq_stat & st_ff.irq_mask);

endmodule : adcc_ctrl

//--- verification/adcc_ctrl_monitor.sv
// Port-level checker for the converter control block.
// Assumes it is bound into adcc_ctrl and shares aclk and aresetn.
`timescale 1ns/1ps
`include "adcc_defines.svh"

module adcc_ctrl_monitor
   import adcc_pkg::*;
(
   input wire logic                aclk,
   input wire logic                aresetn,
   input wire logic                s_axi_awready,
   input wire logic                s_axi_wready,
   input wire logic                s_axi_bvalid,
   input wire logic                s_axi_arvalid,
   input wire logic                s_axi_arready,
   input wire logic [`ADCC_AW-1:0] s_axi_araddr,
   input wire logic                s_axi_rvalid,
   input wire logic                conv_trigger_pin,
   input wire logic                conv_busy,
   input wire logic                irq
);
   // Helper state: busy run length and age of the last pin change
   typedef struct packed {
      logic [6:0] run_len;
      logic [3:0] pin_age;
      logic       pin_q;
   } adcc_mon_t;
   adcc_mon_t mon_ff;   // Registered helper state
   adcc_mon_t nxt_mon;  // Its next value

   // Age saturates so a quiet pin never looks fresh
   always_comb begin
      nxt_mon         = mon_ff;
      nxt_mon.run_len = conv_busy ? mon_ff.run_len + 7'h1 : 7'h0;
      nxt_mon.pin_q   = conv_trigger_pin;
      if (conv_trigger_pin != mon_ff.pin_q) begin
         nxt_mon.pin_age = 4'h0;
      end else if (mon_ff.pin_age != 4'hF) begin
         nxt_mon.pin_age = mon_ff.pin_age + 4'h1;
      end
   end

   // Register the helper state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mon_ff <= '0;
      end else begin
         mon_ff <= nxt_mon;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // A run that ends without a write in flight ran its full period
   sequence s_conv_end;
      $fell(conv_busy) ##0 !s_axi_bvalid;
   endsequence
   // Status register read taken
   sequence s_stat_read;
      s_axi_arvalid && s_axi_arready && (s_axi_araddr == {`ADCC_IDX_IRQ_STAT, 2'h0});
   endsequence

   a_idle_reset: assert property ($rose(aresetn) |-> !conv_busy && !irq)
      else $error("busy or irq set out of reset");
   a_start_cause: assert property ($rose(conv_busy) |-> s_axi_bvalid || mon_ff.pin_age <= 4'h5)
      else $error("conversion started with no write and no pin edge");
   a_period_len: assert property (s_conv_end |-> mon_ff.run_len == {1'b0, `ADCC_PERIOD_SLOW}
      || mon_ff.run_len == {1'b0, `ADCC_PERIOD_FAST})
      else $error("conversion period neither slow nor fast length");
   a_read_turn: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer not one cycle after address taken");
   a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   a_stat_clear: assert property (s_stat_read |=> !irq)
      else $error("irq still high after status read");
endmodule : adcc_ctrl_monitor

bind adcc_ctrl adcc_ctrl_monitor i_adcc_ctrl_monitor (.aclk, .aresetn, .s_axi_awready,
   .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
   .s_axi_rvalid, .conv_trigger_pin, .conv_busy, .irq);

//--- verification/adcc_analog_model.sv
// Stand-in for the analog front end and the external trigger source.
// Assumes the bench calls its tasks from a process clocked on aclk.
`timescale 1ns/1ps

module adcc_analog_model
   import adcc_pkg::*;
(
   input  wire logic  aclk,
   output logic       conv_trigger_pin,
   output logic [7:0] adc_data
);
   // Pin idles low, sample defined from time zero
   initial begin
      conv_trigger_pin = 1'b0;
      adc_data         = 8'h00;
   end
   // One pin step; either direction counts as an edge
   task automatic toggle();
      @(posedge aclk);
      conv_trigger_pin <= ~conv_trigger_pin;
   endtask : toggle
   // New sample, held steady over the whole conversion
   task automatic set_sample(input logic [7:0] v);
      @(posedge aclk);
      adc_data <= v;
   endtask : set_sample
endmodule : adcc_analog_model

//--- verification/test_adc_conversion_control.sv
// Self-checking bench for the converter control block.
// Assumes the analog model stands in for trigger pin and sample data.
`timescale 1ns/1ps
`include "adcc_defines.svh"

module test_adc_conversion_control
   import adcc_pkg::*;
   ;
   logic                aclk = 1'b0;     // 125 MHz clock
   logic                aresetn = 1'b0;  // Synchronous, low active
   logic                s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic                s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [`ADCC_AW-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0]         s_axi_wdata, s_axi_rdata;
   logic [3:0]          s_axi_wstrb, conv_channel;
   logic [1:0]          s_axi_bresp, s_axi_rresp, rsp;
   logic                conv_trigger_pin, conv_busy, irq;
   logic [7:0]          adc_data;
   int                  fails = 0, n_compared = 0, cyc = 0, run_cnt = 0, last_len = 0;
   // Byte addresses, four times the register index
   localparam logic [11:0] adr_mode = {`ADCC_IDX_MODE, 2'h0};
   localparam logic [11:0] adr_res  = {`ADCC_IDX_RESULT, 2'h0};
   localparam logic [11:0] adr_run  = {`ADCC_IDX_START, 2'h0};
   localparam logic [11:0] adr_stat = {`ADCC_IDX_IRQ_STAT, 2'h0};
   localparam logic [11:0] adr_mask = {`ADCC_IDX_IRQ_MASK, 2'h0};

   always #4 aclk = ~aclk;

   adcc_ctrl i_adcc_ctrl (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
      .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
      .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
      .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .conv_trigger_pin, .adc_data,
      .conv_channel, .conv_busy, .irq);
   adcc_analog_model i_adcc_analog_model (.aclk, .conv_trigger_pin, .adc_data);

   // Busy run length in sampled cycles, plus the hang guard
   always @(posedge aclk) begin
      run_cnt <= conv_busy ? run_cnt + 1 : 0;
      if (!conv_busy && run_cnt != 0) last_len <= run_cnt;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         give_verdict();
      end
   end

   // Count one comparison, report a mismatch at once
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk

   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      int t;
      t = 0;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge aclk);
         t++;
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && t < 50);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (t == 50) fails++;
   endtask : wr

   // Read one register and compare data and response
   task automatic expect_rd(input string what, input logic [11:0] a, input logic [31:0] e,
                            input logic [1:0] er);
      int t;
      t = 0;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         t++;
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && t < 50);
      if (t == 50) fails++;
      chk(what, e, s_axi_rdata);
      chk("read response", 32'(er), 32'(s_axi_rresp));
      s_axi_rready <= 1'b0;
   endtask : expect_rd

   // Bounded wait for the end of a run; one more edge lets last_len land
   task automatic wait_idle();
      int t;
      t = 0;
      while (conv_busy !== 1'b0 && t < 200) begin
         @(posedge aclk);
         t++;
      end
      if (t == 200) fails++;
      @(posedge aclk);
   endtask : wait_idle

   // Single place where the run ends
   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : give_verdict

   initial begin
      s_axi_awvalid = 1'b0;
      s_axi_wvalid  = 1'b0;
      s_axi_bready  = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_rready  = 1'b0;
      s_axi_awaddr  = '0;
      s_axi_araddr  = '0;
      s_axi_wdata   = '0;
      s_axi_wstrb   = 4'hF;  // Byte lanes always whole
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      // Reset values, an unmapped place, a refused write
      expect_rd("mode", adr_mode, 32'h30, `ADCC_RESP_OKAY);
      expect_rd("start", adr_run, 32'h7F, `ADCC_RESP_OKAY);
      expect_rd("unmapped", 12'h100, 32'h0, `ADCC_RESP_SLVERR);
      wr(adr_res, 32'h5A, rsp);
      chk("result write", 32'(`ADCC_RESP_OKAY), 32'(rsp));
      wr(12'h100, 32'h1, rsp);
      chk("unmapped write", 32'(`ADCC_RESP_SLVERR), 32'(rsp));
      expect_rd("result", adr_res, 32'h0, `ADCC_RESP_OKAY);
      // Slow then fast period, done interrupt unmasked
      wr(adr_mask, 32'h01, rsp);
      for (int i = 0; i < 2; i++) begin
         i_adcc_analog_model.set_sample(i ? 8'h3C : 8'hA5);
         wr(adr_mode, i ? 32'h80 : 32'h00, rsp);
         wr(adr_run, 32'h80, rsp);
         expect_rd("busy flag", adr_run, 32'hFF, `ADCC_RESP_OKAY);
         wait_idle();
         chk("period", i ? 31 : 62, last_len);
         chk("irq", 32'h1, 32'(irq));
         expect_rd("result", adr_res, i ? 32'h3C : 32'hA5, `ADCC_RESP_OKAY);
         expect_rd("done flag", adr_run, 32'h7F, `ADCC_RESP_OKAY);
         expect_rd("status", adr_stat, 32'h01, `ADCC_RESP_OKAY);
         chk("irq cleared", 32'h0, 32'(irq));
      end
      // Abort mid-run leaves old result and no done event
      i_adcc_analog_model.set_sample(8'h77);
      wr(adr_run, 32'h80, rsp);
      repeat (5) @(posedge aclk);
      wr(adr_run, 32'h00, rsp);
      chk("aborted", 32'h0, 32'(conv_busy));
      repeat (70) @(posedge aclk);
      expect_rd("result kept", adr_res, 32'h3C, `ADCC_RESP_OKAY);
      expect_rd("no done", adr_stat, 32'h00, `ADCC_RESP_OKAY);
      // Pin edges: ignored while disabled, then both edges start
      for (int k = 0; k < 4; k++) begin
         if (k == 2) wr(adr_mode, 32'h45, rsp);
         i_adcc_analog_model.toggle();
         repeat (6) @(posedge aclk);
         chk("busy after pin edge", 32'(k >= 2), 32'(conv_busy));
         wait_idle();
      end
      chk("trigger period", 62, last_len);
      chk("channel", 32'h5, 32'(conv_channel));
      expect_rd("mode", adr_mode, 32'h75, `ADCC_RESP_OKAY);
      expect_rd("status", adr_stat, 32'h03, `ADCC_RESP_OKAY);
      give_verdict();
   end
endmodule : test_adc_conversion_control
